//--- hw/issa_alu.sv
/*
  integer execution slice: shifts, subtract, tagged add/sub, flag tests,
  unsigned divide/remainder, xor and the tail of subroutine return.
  assumes decode holds operands steady while BUSY is high and issues
  a new op only when BUSY is low.
*/
// Notes on behaviour
// - return from register offset moves stack pointer by offset rounded down to 16
// - negative return offset raises illegal instruction instead of executing
// - fetch fault after return saves new target, not return address
// - shift count is the low five source bits only
// - left shift fills vacated low bits with zeros
// - arithmetic right shift replicates the sign bit
// - logical right shift fills vacated high bits with zeros
// - three-operand shifts write accumulator, leave destination alone
// - subtract writes destination minus source to destination or accumulator
// - subtract sets carry on borrow, overflow on signed overflow, else clears
// - tagged ops set test flag on nonzero tag bits, else copy overflow
// - tagged add writes sum only if test flag clear; carry, overflow updated only when tags are clean
// - tagged subtract writes difference only if test flag clear
// - carry test copies carry into test flag then clears carry
// - overflow test copies overflow into test flag then clears overflow
// - unsigned divide writes quotient, clears carry, keeps overflow
// - unsigned remainder writes remainder, clears carry, keeps overflow
// - zero divisor raises zero divide exception and writes nothing
// - xor writes bitwise xor to destination or accumulator
// - return operand must use stack offset mode, else illegal instruction
module issa_alu (
  input  wire logic        CLK_SYS,
  input  wire logic        RST_B,
  input  wire logic        OP_VALID,
  input  wire logic [3:0]  OP_CODE,
  input  wire logic        THREE_OPERAND,
  input  wire logic        STACK_OFFSET_MODE,
  input  wire logic [31:0] SRC_OPERAND,
  input  wire logic [31:0] DST_OPERAND,
  input  wire logic [31:0] STACK_POINTER_IN,
  input  wire logic [31:0] RETURN_TARGET,
  input  wire logic        TARGET_FETCH_FAULT,
  output logic             BUSY,
  output logic             RESULT_VALID,
  output logic [31:0]      RESULT,
  output logic             WRITE_DST,
  output logic             WRITE_ACC,
  output logic             CARRY_FLAG,
  output logic             OVERFLOW_FLAG,
  output logic             TEST_FLAG,
  output logic             STACK_POINTER_WRITE,
  output logic [31:0]      STACK_POINTER,
  output logic             PC_WRITE,
  output logic [31:0]      PC_NEXT,
  output logic             ILLEGAL_INSTR_EXC,
  output logic             ZERO_DIVIDE_EXC,
  output logic             FETCH_FAULT_EXC,
  output logic [31:0]      SAVED_PC
);
  issa_pkg::issa_op_t    op;
  issa_pkg::issa_state_t state;
  logic [4:0]  shamt;
  logic [31:0] shl_res;
  logic [31:0] ashr_res;
  logic [31:0] lshr_res;
  logic [32:0] diff_ext;
  logic [32:0] sum_ext;
  logic        sub_ovf;
  logic        add_ovf;
  logic        tag_bad;
  logic        start_div;
  logic        div_done;
  logic [31:0] div_quot;
  logic [31:0] div_rem;
  logic        div_is_rem;
  logic [31:0] sp_step;
  logic        issue;

  assign op    = issa_pkg::issa_op_t'(OP_CODE);
  assign issue = OP_VALID && (state == issa_pkg::ST_IDLE);

  // ----------------------------------------------------------------
  // combinational datapath
  // ----------------------------------------------------------------
  always_comb begin
    shamt    = SRC_OPERAND[issa_pkg::SHAMT_W-1:0];
    shl_res  = DST_OPERAND << shamt;
    ashr_res = $unsigned($signed(DST_OPERAND) >>> shamt);
    lshr_res = DST_OPERAND >> shamt;
    diff_ext = {1'b0, DST_OPERAND} - {1'b0, SRC_OPERAND};
    sum_ext  = {1'b0, DST_OPERAND} + {1'b0, SRC_OPERAND};
    sub_ovf  = (DST_OPERAND[31] != SRC_OPERAND[31]) && (diff_ext[31] != DST_OPERAND[31]);
    add_ovf  = (DST_OPERAND[31] == SRC_OPERAND[31]) && (sum_ext[31] != DST_OPERAND[31]);
    tag_bad  = (SRC_OPERAND[issa_pkg::TAG_W-1:0] != 2'h0)
             || (DST_OPERAND[issa_pkg::TAG_W-1:0] != 2'h0);
    // low four bits of the offset never reach the stack pointer
    sp_step  = {SRC_OPERAND[31:issa_pkg::SP_ALIGN_W], 4'h0};
  end

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  assign start_div = issue && (op == issa_pkg::OP_UNSIGNED_DIVIDE_OP || op == issa_pkg::OP_UNSIGNED_REMAINDER_OP)
                   && (SRC_OPERAND != issa_pkg::RST_WORD);

  issa_divider u_div (
    .clk       (CLK_SYS),
    .rst_b     (RST_B),
    .start     (start_div),
    .dividend  (DST_OPERAND),
    .divisor   (SRC_OPERAND),
    .done      (div_done),
    .quotient  (div_quot),
    .remainder (div_rem)
  );

  // ----------------------------------------------------------------
  // sequencing: single-cycle ops finish at once, divide iterates
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      state      <= issa_pkg::ST_IDLE;
      BUSY       <= 1'b0;
      div_is_rem <= 1'b0;
    end else begin
      unique case (state)
        issa_pkg::ST_IDLE: begin
          if (start_div) begin
            state      <= issa_pkg::ST_DIV;
            BUSY       <= 1'b1;
            div_is_rem <= (op == issa_pkg::OP_UNSIGNED_REMAINDER_OP);
          end
        end
        issa_pkg::ST_DIV: begin
          if (div_done) begin
            state <= issa_pkg::ST_DONE;
          end
        end
        issa_pkg::ST_DONE: begin
          state <= issa_pkg::ST_IDLE;
          BUSY  <= 1'b0;
        end
        default: begin
          state <= issa_pkg::ST_IDLE;
          BUSY  <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // result and write enables
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      RESULT_VALID <= 1'b0;
      RESULT       <= issa_pkg::RST_WORD;
      WRITE_DST    <= 1'b0;
      WRITE_ACC    <= 1'b0;
    end else begin
      RESULT_VALID <= 1'b0;
      WRITE_DST    <= 1'b0;
      WRITE_ACC    <= 1'b0;
      if (state == issa_pkg::ST_DIV && div_done) begin
        RESULT_VALID <= 1'b1;
        WRITE_DST    <= 1'b1;
        RESULT       <= div_is_rem ? div_rem : div_quot;
      end else if (issue) begin
        unique case (op)
          issa_pkg::OP_SHIFT_LEFT, issa_pkg::OP_ARITH_SHR,
          issa_pkg::OP_LOGIC_SHR, issa_pkg::OP_SUBTRACT, issa_pkg::OP_XOR: begin
            RESULT_VALID <= 1'b1;
            WRITE_ACC    <= THREE_OPERAND;
            WRITE_DST    <= !THREE_OPERAND;
            if (op == issa_pkg::OP_SHIFT_LEFT) begin
              RESULT <= shl_res;
            end else if (op == issa_pkg::OP_ARITH_SHR) begin
              RESULT <= ashr_res;
            end else if (op == issa_pkg::OP_LOGIC_SHR) begin
              RESULT <= lshr_res;
            end else if (op == issa_pkg::OP_SUBTRACT) begin
              RESULT <= diff_ext[31:0];
            end else begin
              RESULT <= DST_OPERAND ^ SRC_OPERAND;
            end
          end
          issa_pkg::OP_TAGGED_ADD: begin
            RESULT_VALID <= 1'b1;
            RESULT       <= sum_ext[31:0];
            WRITE_DST    <= !(tag_bad || add_ovf);
          end
          issa_pkg::OP_TAGGED_SUB: begin
            RESULT_VALID <= 1'b1;
            RESULT       <= diff_ext[31:0];
            WRITE_DST    <= !(tag_bad || sub_ovf);
          end
          default: begin
            RESULT <= RESULT;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      CARRY_FLAG    <= issa_pkg::RST_FLAG;
      OVERFLOW_FLAG <= issa_pkg::RST_FLAG;
      TEST_FLAG     <= issa_pkg::RST_FLAG;
    end else if (issue) begin
      unique case (op)
        issa_pkg::OP_SUBTRACT: begin
          CARRY_FLAG    <= diff_ext[32];
          OVERFLOW_FLAG <= sub_ovf;
        end
        issa_pkg::OP_TAGGED_ADD: begin
          // on a bad tag the arithmetic flags are not touched
          if (tag_bad) begin
            TEST_FLAG <= 1'b1;
          end else begin
            CARRY_FLAG    <= sum_ext[32];
            OVERFLOW_FLAG <= add_ovf;
            TEST_FLAG     <= add_ovf;
          end
        end
        issa_pkg::OP_TAGGED_SUB: begin
          if (tag_bad) begin
            TEST_FLAG <= 1'b1;
          end else begin
            CARRY_FLAG    <= diff_ext[32];
            OVERFLOW_FLAG <= sub_ovf;
            TEST_FLAG     <= sub_ovf;
          end
        end
        issa_pkg::OP_CARRY_TEST: begin
          TEST_FLAG  <= CARRY_FLAG;
          CARRY_FLAG <= 1'b0;
        end
        issa_pkg::OP_OVF_TEST: begin
          TEST_FLAG     <= OVERFLOW_FLAG;
          OVERFLOW_FLAG <= 1'b0;
        end
        issa_pkg::OP_UNSIGNED_DIVIDE_OP, issa_pkg::OP_UNSIGNED_REMAINDER_OP: begin
          if (SRC_OPERAND != issa_pkg::RST_WORD) begin
            CARRY_FLAG <= 1'b0;
          end
        end
        default: begin
          CARRY_FLAG <= CARRY_FLAG;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // exceptions and return tail
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      ILLEGAL_INSTR_EXC   <= 1'b0;
      ZERO_DIVIDE_EXC     <= 1'b0;
      FETCH_FAULT_EXC     <= 1'b0;
      SAVED_PC            <= issa_pkg::RST_WORD;
      STACK_POINTER_WRITE <= 1'b0;
      STACK_POINTER       <= issa_pkg::RST_WORD;
      PC_WRITE            <= 1'b0;
      PC_NEXT             <= issa_pkg::RST_WORD;
    end else begin
      ILLEGAL_INSTR_EXC   <= 1'b0;
      ZERO_DIVIDE_EXC     <= 1'b0;
      FETCH_FAULT_EXC     <= 1'b0;
      STACK_POINTER_WRITE <= 1'b0;
      PC_WRITE            <= 1'b0;
      if (issue && (op == issa_pkg::OP_UNSIGNED_DIVIDE_OP || op == issa_pkg::OP_UNSIGNED_REMAINDER_OP)
          && SRC_OPERAND == issa_pkg::RST_WORD) begin
        ZERO_DIVIDE_EXC <= 1'b1;
      end
      if (issue && op == issa_pkg::OP_RETURN) begin
        if (!STACK_OFFSET_MODE || SRC_OPERAND[31]) begin
          ILLEGAL_INSTR_EXC <= 1'b1;
        end else begin
          STACK_POINTER_WRITE <= 1'b1;
          STACK_POINTER       <= STACK_POINTER_IN + sp_step;
          PC_WRITE            <= 1'b1;
          PC_NEXT             <= RETURN_TARGET;
          if (TARGET_FETCH_FAULT) begin
            FETCH_FAULT_EXC <= 1'b1;
            SAVED_PC        <= RETURN_TARGET;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_ret_ok;
    issue && op == issa_pkg::OP_RETURN && STACK_OFFSET_MODE && !SRC_OPERAND[31];
  endsequence

  a_ret_sp_step: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    s_ret_ok |=> STACK_POINTER_WRITE && STACK_POINTER[3:0] == $past(STACK_POINTER_IN[3:0]))
    else $error("stack pointer moved by unaligned amount");
  a_ret_illegal: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    issue && op == issa_pkg::OP_RETURN && SRC_OPERAND[31] |=> ILLEGAL_INSTR_EXC && !PC_WRITE)
    else $error("negative return offset not trapped");
  a_fault_pc: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    s_ret_ok ##0 TARGET_FETCH_FAULT |=> FETCH_FAULT_EXC && SAVED_PC == $past(RETURN_TARGET))
    else $error("saved pc is not return target");
  a_shift_left: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    issue && op == issa_pkg::OP_SHIFT_LEFT |=> RESULT == ($past(DST_OPERAND) << $past(SRC_OPERAND[4:0])))
    else $error("left shift result wrong");
  a_sub_flags: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    issue && op == issa_pkg::OP_SUBTRACT |=> CARRY_FLAG == ($past(DST_OPERAND) < $past(SRC_OPERAND)))
    else $error("subtract carry wrong");
  a_tag_flag: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    issue && (op == issa_pkg::OP_TAGGED_ADD || op == issa_pkg::OP_TAGGED_SUB) && tag_bad
      |=> TEST_FLAG && !WRITE_DST)
    else $error("bad tag not flagged");
  a_carry_test: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    issue && op == issa_pkg::OP_CARRY_TEST |=> TEST_FLAG == $past(CARRY_FLAG) && !CARRY_FLAG)
    else $error("carry test wrong");
  a_div_zero: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    issue && op == issa_pkg::OP_UNSIGNED_DIVIDE_OP && SRC_OPERAND == issa_pkg::RST_WORD
      |=> ZERO_DIVIDE_EXC ##1 !RESULT_VALID [*3])
    else $error("zero divide not raised");
  a_div_finish: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    start_div |-> ##[33:34] (RESULT_VALID && WRITE_DST && !CARRY_FLAG))
    else $error("divide did not finish in time");
  a_xor_flags: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    issue && op == issa_pkg::OP_XOR |=> $stable(CARRY_FLAG) && $stable(OVERFLOW_FLAG)
      && $stable(TEST_FLAG))
    else $error("xor touched flags");
endmodule // issa_alu

//--- hw/issa_pkg.sv
/*
  shared constants and types for the integer shift/subtract/tag datapath.
  assumes a 32-bit word and a single core clock.
*/
package issa_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int WORD_W      = 32;
  localparam int SHAMT_W     = 5;
  localparam int TAG_W       = 2;
  localparam int SP_ALIGN_W  = 4;    // stack moves in steps of 16
  localparam int DIV_STEPS   = 32;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic        RST_FLAG = 1'b0;

  // ----------------------------------------------------------------
  // operation codes presented by decode
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_SHIFT_LEFT   = 4'h0,
    OP_ARITH_SHR    = 4'h1,
    OP_LOGIC_SHR    = 4'h2,
    OP_SUBTRACT     = 4'h3,
    OP_TAGGED_ADD   = 4'h4,
    OP_TAGGED_SUB   = 4'h5,
    OP_CARRY_TEST   = 4'h6,
    OP_OVF_TEST     = 4'h7,
    OP_UNSIGNED_DIVIDE_OP         = 4'h8,
    OP_UNSIGNED_REMAINDER_OP         = 4'h9,
    OP_XOR          = 4'ha,
    OP_RETURN       = 4'hb
  } issa_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DIV  = 3'b010,
    ST_DONE = 3'b100
  } issa_state_t;
endpackage

//--- hw/issa_divider.sv
/*
  unsigned restoring divider, one quotient bit per cycle.
  assumes operands stay free to change once start has been seen.
*/
module issa_divider (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        start,
  input  wire logic [31:0] dividend,
  input  wire logic [31:0] divisor,
  output logic             done,
  output logic [31:0]      quotient,
  output logic [31:0]      remainder
);
  logic [31:0] dvsr;
  logic [5:0]  count;
  logic        busy;
  logic [32:0] trial;

  // --------------------------------------------------------------
  // iteration
  // --------------------------------------------------------------
  always_comb begin
    trial = {remainder, quotient[31]} - {1'b0, dvsr};
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy      <= 1'b0;
      done      <= 1'b0;
      count     <= 6'h00;
      dvsr      <= issa_pkg::RST_WORD;
      quotient  <= issa_pkg::RST_WORD;
      remainder <= issa_pkg::RST_WORD;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy      <= 1'b1;
        count     <= 6'(issa_pkg::DIV_STEPS);
        dvsr      <= divisor;
        quotient  <= dividend;
        remainder <= issa_pkg::RST_WORD;
      end else if (busy) begin
        if (trial[32]) begin
          remainder <= {remainder[30:0], quotient[31]};
          quotient  <= {quotient[30:0], 1'b0};
        end else begin
          remainder <= trial[31:0];
          quotient  <= {quotient[30:0], 1'b1};
        end
        count <= count - 6'h01;
        if (count == 6'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule // issa_divider

//--- sim/issa_decode_model.sv
/*
  decode and pipeline model that feeds the alu slice its operations.
  assumes the bench calls its tasks at a falling edge of the core clock.
*/
module issa_decode_model (
  input  wire logic        clk,
  input  wire logic        busy,
  output logic             op_valid,
  output logic [3:0]       op_code,
  output logic             three_operand,
  output logic             stack_offset_mode,
  output logic [31:0]      src_operand,
  output logic [31:0]      dst_operand,
  output logic [31:0]      stack_pointer_in,
  output logic [31:0]      return_target,
  output logic             target_fetch_fault
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {op_valid, op_code, three_operand, stack_offset_mode} = '0;
    {src_operand, dst_operand, stack_pointer_in, return_target} = '0;
    target_fetch_fault = 1'b0;
  end

  // operands stay put until the next issue, so they are steady while busy
  task automatic issue(input logic [3:0] op, input logic th, som,
                       input logic [31:0] src, dst, sp, tgt, input logic ff);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 64) begin
      @(negedge clk);
      n++;
    end
    if (n >= 64) begin
      issa_alu_tb_top.err_count++;
      issa_alu_tb_top.final_report();
    end
    op_valid = 1'b1;
    op_code = op;
    three_operand = th;
    stack_offset_mode = som;
    src_operand = src;
    dst_operand = dst;
    stack_pointer_in = sp;
    return_target = tgt;
    target_fetch_fault = ff;
    @(negedge clk);
  endtask

  task automatic idle();
    op_valid = 1'b0;
  endtask
endmodule // issa_decode_model

//--- sim/issa_alu_tb_top.sv
/*
  self-checking bench for the alu slice: table of ordinary ops, then
  divide-by-zero and subroutine-return cases by hand.
  assumes the decode model drives all operation inputs.
*/
module issa_alu_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    issa_pkg::issa_op_t op;
    logic               th;
    logic [31:0]        src;
    logic [31:0]        dst;
    logic [31:0]        res;
    logic               wd;
    logic               wa;
    logic [2:0]         cvf;
  } issa_row_t;

  logic        CLK_SYS = 1'b0;
  logic        RST_B = 1'b0;
  logic        op_valid, three_operand, stack_offset_mode, target_fetch_fault;
  logic [3:0]  op_code;
  logic [31:0] src_operand, dst_operand, stack_pointer_in, return_target;
  logic        busy, result_valid, write_dst, write_acc;
  logic        carry_flag, overflow_flag, test_flag;
  logic        sp_write, pc_write, ill_exc, zdiv_exc, ff_exc;
  logic [31:0] result, stack_pointer, pc_next, saved_pc;
  int          err_count = 0;
  int          compares = 0;
  int          n;
  logic        seen_rv;

  always #4 CLK_SYS = ~CLK_SYS;

  issa_decode_model u_issa_decode_model (
    .clk(CLK_SYS), .busy(busy), .op_valid(op_valid), .op_code(op_code),
    .three_operand(three_operand), .stack_offset_mode(stack_offset_mode),
    .src_operand(src_operand), .dst_operand(dst_operand),
    .stack_pointer_in(stack_pointer_in), .return_target(return_target),
    .target_fetch_fault(target_fetch_fault));

  issa_alu u_issa_alu (
    .CLK_SYS(CLK_SYS), .RST_B(RST_B), .OP_VALID(op_valid), .OP_CODE(op_code),
    .THREE_OPERAND(three_operand), .STACK_OFFSET_MODE(stack_offset_mode),
    .SRC_OPERAND(src_operand), .DST_OPERAND(dst_operand),
    .STACK_POINTER_IN(stack_pointer_in), .RETURN_TARGET(return_target),
    .TARGET_FETCH_FAULT(target_fetch_fault), .BUSY(busy),
    .RESULT_VALID(result_valid), .RESULT(result), .WRITE_DST(write_dst),
    .WRITE_ACC(write_acc), .CARRY_FLAG(carry_flag), .OVERFLOW_FLAG(overflow_flag),
    .TEST_FLAG(test_flag), .STACK_POINTER_WRITE(sp_write),
    .STACK_POINTER(stack_pointer), .PC_WRITE(pc_write), .PC_NEXT(pc_next),
    .ILLEGAL_INSTR_EXC(ill_exc), .ZERO_DIVIDE_EXC(zdiv_exc),
    .FETCH_FAULT_EXC(ff_exc), .SAVED_PC(saved_pc));

  // ----------------------------------------------------------------
  // rows run in order: flags carry over from one row to the next
  // ----------------------------------------------------------------
  issa_row_t rows[20] = '{
    '{issa_pkg::OP_SUBTRACT,   0, 32'h3, 32'h5, 32'h2, 1, 0, 3'b000},
    '{issa_pkg::OP_SUBTRACT,   1, 32'h1, 32'h0, 32'hffff_ffff, 0, 1, 3'b100},
    '{issa_pkg::OP_SUBTRACT,   0, 32'h1, 32'h8000_0000, 32'h7fff_ffff, 1, 0, 3'b010},
    '{issa_pkg::OP_SHIFT_LEFT, 0, 32'hffff_ffe4, 32'hf, 32'hf0, 1, 0, 3'b010},
    '{issa_pkg::OP_ARITH_SHR,  1, 32'h21, 32'h8000_0000, 32'hc000_0000, 0, 1, 3'b010},
    '{issa_pkg::OP_LOGIC_SHR,  0, 32'h3f, 32'h8000_0000, 32'h1, 1, 0, 3'b010},
    '{issa_pkg::OP_XOR,        1, 32'hff00_ff00, 32'h0ff0_0ff0, 32'hf0f0_f0f0, 0, 1, 3'b010},
    '{issa_pkg::OP_OVF_TEST,   0, 32'h0, 32'h0, 32'h0, 0, 0, 3'b001},
    '{issa_pkg::OP_SUBTRACT,   0, 32'h1, 32'h0, 32'hffff_ffff, 1, 0, 3'b101},
    '{issa_pkg::OP_SHIFT_LEFT, 1, 32'h20, 32'h1234_5678, 32'h1234_5678, 0, 1, 3'b101},
    '{issa_pkg::OP_CARRY_TEST, 0, 32'h0, 32'h0, 32'h0, 0, 0, 3'b001},
    '{issa_pkg::OP_TAGGED_ADD, 0, 32'h4, 32'h8, 32'hc, 1, 0, 3'b000},
    '{issa_pkg::OP_TAGGED_ADD, 0, 32'h1, 32'h8, 32'h0, 0, 0, 3'b001},
    '{issa_pkg::OP_TAGGED_ADD, 0, 32'h4, 32'h7fff_fffc, 32'h0, 0, 0, 3'b011},
    '{issa_pkg::OP_TAGGED_ADD, 0, 32'h4, 32'hffff_fffc, 32'h0, 1, 0, 3'b100},
    '{issa_pkg::OP_TAGGED_SUB, 0, 32'h4, 32'h0, 32'hffff_fffc, 1, 0, 3'b100},
    '{issa_pkg::OP_TAGGED_SUB, 0, 32'h0, 32'h2, 32'h0, 0, 0, 3'b101},
    '{issa_pkg::OP_TAGGED_SUB, 0, 32'h4, 32'h8000_0000, 32'h0, 0, 0, 3'b011},
    '{issa_pkg::OP_UNSIGNED_DIVIDE_OP,       0, 32'h7, 32'h64, 32'he, 1, 0, 3'b011},
    '{issa_pkg::OP_UNSIGNED_REMAINDER_OP,       0, 32'h7, 32'h64, 32'h2, 1, 0, 3'b011}};

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic ret_case(input logic [31:0] src, input logic som, ff, wr,
                          input logic [31:0] sp, input logic ill);
    u_issa_decode_model.issue(issa_pkg::OP_RETURN, 1'b0, som, src, 32'h0,
                              32'h0000_1000, 32'h0000_4444, ff);
    chk({sp_write, pc_write, ill_exc, ff_exc}, {wr, wr, ill, ff});
    if (wr) chk(stack_pointer, sp);
    if (wr) chk(pc_next, 32'h0000_4444);
    if (ff) chk(saved_pc, 32'h0000_4444);
  endtask

  initial begin
    repeat (4) @(negedge CLK_SYS);
    RST_B = 1'b1;
    chk({busy, result_valid, carry_flag, overflow_flag, test_flag}, 32'h0);
    chk(result, 32'h0);
    foreach (rows[i]) begin
      u_issa_decode_model.issue(rows[i].op, rows[i].th, 1'b0, rows[i].src,
                                rows[i].dst, 32'h0, 32'h0, 1'b0);
      n = 1;
      if (rows[i].op inside {issa_pkg::OP_UNSIGNED_DIVIDE_OP, issa_pkg::OP_UNSIGNED_REMAINDER_OP}) begin
        u_issa_decode_model.idle();
        chk(busy, 1'b1);
        while (result_valid !== 1'b1 && n < 40) begin
          @(negedge CLK_SYS);
          n++;
        end
        chk(32'(n), 32'd34);
        if (n >= 40) final_report();
      end
      if (rows[i].wd | rows[i].wa) chk(result, rows[i].res);
      chk({write_dst, write_acc}, {rows[i].wd, rows[i].wa});
      chk({carry_flag, overflow_flag, test_flag}, rows[i].cvf);
    end
    // ----------------------------------------------------------------
    // zero divisor: carry set beforehand must survive
    // ----------------------------------------------------------------
    u_issa_decode_model.issue(issa_pkg::OP_SUBTRACT, 1'b0, 1'b0, 32'h1, 32'h0,
                              32'h0, 32'h0, 1'b0);
    for (int k = 0; k < 2; k++) begin
      u_issa_decode_model.issue(k ? issa_pkg::OP_UNSIGNED_REMAINDER_OP : issa_pkg::OP_UNSIGNED_DIVIDE_OP, 1'b0,
                                1'b0, 32'h0, 32'h64, 32'h0, 32'h0, 1'b0);
      u_issa_decode_model.idle();
      n = 1;
      seen_rv = result_valid;
      chk(zdiv_exc, 1'b1);
      // watch past the point where a real divide would have answered
      while (n < 36) begin
        @(negedge CLK_SYS);
        seen_rv |= result_valid | busy;
        n++;
      end
      chk({seen_rv, carry_flag}, 2'b01);
    end
    // ----------------------------------------------------------------
    // subroutine return tail, back to back
    // ----------------------------------------------------------------
    ret_case(32'h24, 1'b1, 1'b0, 1'b1, 32'h1020, 1'b0);
    ret_case(32'h4, 1'b1, 1'b0, 1'b1, 32'h1000, 1'b0);
    ret_case(32'hffff_fff0, 1'b1, 1'b0, 1'b0, 32'h0, 1'b1);
    ret_case(32'h10, 1'b0, 1'b0, 1'b0, 32'h0, 1'b1);
    ret_case(32'h10, 1'b1, 1'b1, 1'b1, 32'h1010, 1'b0);
    u_issa_decode_model.idle();
    // ----------------------------------------------------------------
    // mid-run reset clears held flags and return state
    // ----------------------------------------------------------------
    RST_B = 1'b0;
    repeat (2) @(negedge CLK_SYS);
    RST_B = 1'b1;
    chk({busy, carry_flag, overflow_flag, test_flag, ff_exc}, 32'h0);
    chk(saved_pc, 32'h0);
    chk(stack_pointer, 32'h0);
    repeat (2) @(negedge CLK_SYS);
    final_report();
  end
endmodule // issa_alu_tb_top
